// file: iatp_cfg.svh
// Offsets, field positions, reset values and vector constants of the interrupt and trap block
`ifndef IATP_CFG_SVH
`define IATP_CFG_SVH

`define IATP_ADDR_W        12
`define IATP_OFS_EXC_FLAG  12'h000
`define IATP_OFS_EXC_CLR   12'h004
`define IATP_OFS_EXC_EN    12'h008
`define IATP_OFS_CPU_STAT  12'h00c
`define IATP_OFS_SRC_BASE  12'h100

`define IATP_GROUP_LEVEL_LSB      0
`define IATP_GROUP_LEVEL_MSB      1
`define IATP_PRIORITY_LEVEL_LSB      2
`define IATP_PRIORITY_LEVEL_MSB      5
`define IATP_IE_BIT        6
`define IATP_IR_BIT        7
`define IATP_CTRL_RST      8'h00
`define IATP_MAX_LEVEL     4'hf

`define IATP_NUM_FLAGS     9
`define IATP_FLG_NMI       0
`define IATP_FLG_STACK_OVERFLOW_FLAG     1
`define IATP_FLG_STACK_UNDERFLOW_FLAG     2
`define IATP_FLG_B_LO      3
`define IATP_FLG_B_HI      7
`define IATP_FLG_RESET     8

`define IATP_VEC_RESET     24'h000000
`define IATP_VEC_NMI       24'h000008
`define IATP_VEC_STACK_OVERFLOW_FLAG     24'h000010
`define IATP_VEC_STACK_UNDERFLOW_FLAG     24'h000018
`define IATP_VEC_CLASS_B   24'h000028
`define IATP_NUM_RESET     8'h00
`define IATP_NUM_NMI       8'h02
`define IATP_NUM_STACK_OVERFLOW_FLAG     8'h04
`define IATP_NUM_STACK_UNDERFLOW_FLAG     8'h06
`define IATP_NUM_CLASS_B   8'h0a
`define IATP_SRC_TRAP_BASE 8'h10

`endif

// file: iatp_pkg.sv
// Types shared by the interrupt and trap block
package iatp_pkg;

  typedef enum logic [1:0] {
    CLS_NONE,
    CLS_B,
    CLS_A,
    CLS_RESET
  } iatp_class_e;

  typedef enum logic [1:0] {
    KIND_INT,
    KIND_TRAP,
    KIND_SW
  } iatp_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_OFFER,
    ST_TRAP_SVC
  } iatp_state_e;

  // Numeric rank of a trap class, higher wins
  function automatic logic [1:0] iatp_rank(input iatp_class_e c);
    case (c)
      CLS_RESET: iatp_rank = 2'h3;
      CLS_A:     iatp_rank = 2'h2;
      CLS_B:     iatp_rank = 2'h1;
      default:   iatp_rank = 2'h0;
    endcase
  endfunction

endpackage

// file: iatp_arbiter.sv
// Priority arbiter over the source control registers
`timescale 1ns/1ps
module iatp_arbiter
  import iatp_pkg::*;
#(
  parameter int NUM_SRC = 56
) (
  input  logic [7:0]                   ctrl [NUM_SRC],
  input  logic [3:0]                   cpuLevel,
  output logic                         found,
  output logic [$clog2(NUM_SRC)-1:0]   idx,
  output logic [3:0]                   level
);
  `include "iatp_cfg.svh"

  localparam int IW = $clog2(NUM_SRC);

  // Elaboration check of the source count
  if (NUM_SRC < 2 || NUM_SRC > 128) begin : g_badCount
    $error("NUM_SRC out of range");
  end

  // Highest level first, then highest group; lower index on a full tie
  always_comb begin
    logic [5:0] best;
    logic [5:0] key;
    logic       elig;
    key   = 6'h00;
    elig  = 1'b0;
    best  = 6'h00;
    found = 1'b0;
    idx   = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      key  = {ctrl[i][`IATP_PRIORITY_LEVEL_MSB:`IATP_PRIORITY_LEVEL_LSB], ctrl[i][`IATP_GROUP_LEVEL_MSB:`IATP_GROUP_LEVEL_LSB]};
      elig = ctrl[i][`IATP_IR_BIT] && ctrl[i][`IATP_IE_BIT]
             && (ctrl[i][`IATP_PRIORITY_LEVEL_MSB:`IATP_PRIORITY_LEVEL_LSB] > cpuLevel);
      if (elig && (!found || key > best)) begin
        best  = key;
        found = 1'b1;
        idx   = IW'(i);
      end
    end
    level = best[5:2];
  end
endmodule

// file: iatp_trap_unit.sv
// Pending hardware traps and their fixed priority, vector and number
`timescale 1ns/1ps
`include "iatp_cfg.svh"
module iatp_trap_unit
  import iatp_pkg::*;
(
  input  logic                        clk,
  input  logic                        srst,
  input  logic                        ce,
  input  logic [`IATP_NUM_FLAGS-1:0]  trapEvt,
  input  logic                        ackTrap,
  output logic                        hasTrap,
  output iatp_class_e                 trapClass,
  output logic [23:0]                 trapVec,
  output logic [7:0]                  trapNum
);

  logic [`IATP_NUM_FLAGS-1:0] pend_reg;
  logic [`IATP_NUM_FLAGS-1:0] ackMask;
  logic                       selReset;
  logic                       selNmi;
  logic                       selStkOf;
  logic                       selStkUf;
  logic                       selB;

  // Fixed order: resets, then class A one by one, then class B as a group
  assign selReset = pend_reg[`IATP_FLG_RESET];
  assign selNmi   = !selReset && pend_reg[`IATP_FLG_NMI];
  assign selStkOf = !selReset && !pend_reg[`IATP_FLG_NMI] && pend_reg[`IATP_FLG_STACK_OVERFLOW_FLAG];
  assign selStkUf = !selReset && !pend_reg[`IATP_FLG_NMI] && !pend_reg[`IATP_FLG_STACK_OVERFLOW_FLAG]
                    && pend_reg[`IATP_FLG_STACK_UNDERFLOW_FLAG];
  assign selB     = !selReset && (pend_reg[`IATP_FLG_STACK_UNDERFLOW_FLAG:`IATP_FLG_NMI] == 3'h0)
                    && |pend_reg[`IATP_FLG_B_HI:`IATP_FLG_B_LO];
  assign hasTrap  = |pend_reg;
  assign trapClass = selReset ? CLS_RESET : (selB ? CLS_B : (hasTrap ? CLS_A : CLS_NONE));
  assign trapVec  = selReset ? `IATP_VEC_RESET : selNmi ? `IATP_VEC_NMI : selStkOf ? `IATP_VEC_STACK_OVERFLOW_FLAG
                    : selStkUf ? `IATP_VEC_STACK_UNDERFLOW_FLAG : `IATP_VEC_CLASS_B;
  assign trapNum  = selReset ? `IATP_NUM_RESET : selNmi ? `IATP_NUM_NMI : selStkOf ? `IATP_NUM_STACK_OVERFLOW_FLAG
                    : selStkUf ? `IATP_NUM_STACK_UNDERFLOW_FLAG : `IATP_NUM_CLASS_B;

  // Acknowledge retires the selected trap; class B retires all its causes
  assign ackMask = {selReset, {5{selB}}, selStkUf, selStkOf, selNmi} & {`IATP_NUM_FLAGS{ackTrap}};

  // Pending set wins over acknowledge; a reset trap is pending after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_reg <= `IATP_NUM_FLAGS'(1) << `IATP_FLG_RESET;
    end else if (ce) begin
      pend_reg <= (pend_reg & ~ackMask) | trapEvt;
    end
  end
endmodule

// file: iatp_top.sv
// Interrupt control registers, arbitration and trap sequencing with an Avalon-MM slave
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module iatp_top
  import iatp_pkg::*;
#(
  parameter int NUM_SRC = 56
) (
  input  logic                   clk,
  input  logic                   srst,
  input  logic                   ce,
  input  logic [11:0]            avsAddress,
  input  logic                   avsRead,
  input  logic                   avsWrite,
  input  logic [31:0]            avsWritedata,
  input  logic [3:0]             avsByteenable,
  output logic [31:0]            avsReaddata,
  output logic                   avsWaitrequest,
  input  logic [NUM_SRC-1:0]     srcReq,
  input  logic                   swResetEvt,
  input  logic                   wdtOverflowEvt,
  input  logic                   nmiEvt,
  input  logic                   stackOverflowEvt,
  input  logic                   stackUnderflowEvt,
  input  logic [4:0]             classBEvt,
  input  logic                   swTrapReq,
  input  logic [6:0]             swTrapNum,
  input  logic [3:0]             cpuLevel,
  input  logic                   cpuAck,
  input  logic                   trapDone,
  output logic                   offerValid,
  output logic [23:0]            offerVector,
  output logic [7:0]             offerTrapNum,
  output logic                   offerIsTrap,
  output logic                   pswForceMax,
  output logic [3:0]             pswLevel,
  output logic                   irq
);
  `include "iatp_cfg.svh"

  localparam int IW = $clog2(NUM_SRC);

  // Elaboration check of the source count
  if (NUM_SRC < 2 || NUM_SRC > 128) begin : g_badCount
    $error("NUM_SRC out of range");
  end

  // Source index decode of a bus address, shared by read and write paths
  function automatic logic [7:0] srcIndex(input logic [11:0] a);
    logic [11:0] d;
    d = a - `IATP_OFS_SRC_BASE;
    srcIndex = d[9:2];
  endfunction

  function automatic logic srcHit(input logic [11:0] a);
    srcHit = (a >= `IATP_OFS_SRC_BASE) && (a[1:0] == 2'h0)
             && (srcIndex(a) < 8'(NUM_SRC));
  endfunction

  logic [7:0]                  ctrl_reg [NUM_SRC];
  logic [`IATP_NUM_FLAGS-1:0]  flag_reg;
  logic [`IATP_NUM_FLAGS-1:0]  flagEn_reg;
  logic                        wait_reg;
  logic [31:0]                 rdata_reg;
  logic                        irq_reg;
  iatp_state_e                 state_reg;
  iatp_state_e                 state_next;
  iatp_kind_e                  kind_reg;
  logic [IW-1:0]               grantIdx_reg;
  logic [1:0]                  svcRank_reg;
  logic [1:0]                  offerRank_reg;
  logic                        swPend_reg;
  logic [6:0]                  swNum_reg;
  logic                        offer_reg;
  logic [23:0]                 vec_reg;
  logic [7:0]                  num_reg;
  logic                        forceMax_reg;
  logic                        isTrap_reg;
  logic [3:0]                  pswLevel_reg;

  logic                        busReq;
  logic                        wrFire;
  logic                        wrSrc;
  logic [7:0]                  wrIdx;
  logic                        wrClr;
  logic                        wrEn;
  logic [31:0]                 rdMux;
  logic [7:0]                  rdSrcByte;
  logic                        arbFound;
  logic [IW-1:0]               arbIdx;
  logic [3:0]                  arbLevel;
  logic                        hasTrap;
  iatp_class_e                 trapClass;
  logic [23:0]                 trapVec;
  logic [7:0]                  trapNum;
  logic [`IATP_NUM_FLAGS-1:0]  trapEvt;
  logic                        ackTrap;
  logic                        ackInt;
  logic                        ackSw;
  logic                        trapOk;
  logic                        intOk;
  logic                        swOk;
  logic [1:0]                  trapRank;
  logic                        forceNext;

  // Bus decode: request answered one cycle after it is seen
  assign busReq    = (avsRead || avsWrite) && wait_reg;
  assign wrFire    = avsWrite && !wait_reg;
  assign wrSrc     = wrFire && srcHit(avsAddress) && avsByteenable[0];
  assign wrIdx     = srcIndex(avsAddress);
  assign wrClr     = wrFire && (avsAddress == `IATP_OFS_EXC_CLR);
  assign wrEn      = wrFire && (avsAddress == `IATP_OFS_EXC_EN);
  assign rdSrcByte = srcHit(avsAddress) ? ctrl_reg[wrIdx[IW-1:0]] : 8'h00;
  assign rdMux     = srcHit(avsAddress) ? {24'h000000, rdSrcByte}
                   : (avsAddress == `IATP_OFS_EXC_FLAG) ? 32'(flag_reg)
                   : (avsAddress == `IATP_OFS_EXC_EN) ? 32'(flagEn_reg)
                   : (avsAddress == `IATP_OFS_CPU_STAT)
                     ? {21'h000000, forceMax_reg, svcRank_reg, state_reg, swPend_reg, 1'b0, cpuLevel}
                   : 32'h00000000;

  // Bus handshake and read data capture
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else if (ce) begin
      wait_reg  <= !busReq;
      rdata_reg <= busReq && avsRead ? rdMux : rdata_reg;
    end
  end

  // Trap causes in flag-bit order; software and watchdog resets share one bit
  assign trapEvt = {swResetEvt || wdtOverflowEvt, classBEvt,
                    stackUnderflowEvt, stackOverflowEvt, nmiEvt};

  iatp_trap_unit u_trap (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .trapEvt   (trapEvt),
    .ackTrap   (ackTrap),
    .hasTrap   (hasTrap),
    .trapClass (trapClass),
    .trapVec   (trapVec),
    .trapNum   (trapNum)
  );

  iatp_arbiter #(
    .NUM_SRC (NUM_SRC)
  ) u_arb (
    .ctrl     (ctrl_reg),
    .cpuLevel (cpuLevel),
    .found    (arbFound),
    .idx      (arbIdx),
    .level    (arbLevel)
  );

  // Source control registers; hardware request set beats any clear
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    logic hit;
    logic irNext;
    assign hit    = wrSrc && (wrIdx == 8'(i));
    assign irNext = srcReq[i] ? 1'b1
                  : hit ? avsWritedata[`IATP_IR_BIT]
                  : (ackInt && grantIdx_reg == IW'(i)) ? 1'b0
                  : ctrl_reg[i][`IATP_IR_BIT];
    always_ff @(posedge clk) begin
      if (srst) begin
        ctrl_reg[i] <= `IATP_CTRL_RST;
      end else if (ce) begin
        ctrl_reg[i][`IATP_IR_BIT] <= irNext;
        if (hit) begin
          ctrl_reg[i][`IATP_IE_BIT:0] <= avsWritedata[`IATP_IE_BIT:0];
        end
      end
    end
  end

  // Exception flags: sticky, set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_reg   <= '0;
      flagEn_reg <= '0;
      irq_reg    <= 1'b0;
    end else if (ce) begin
      flag_reg   <= (flag_reg & ~(wrClr ? avsWritedata[`IATP_NUM_FLAGS-1:0] : '0)) | trapEvt;
      flagEn_reg <= wrEn ? avsWritedata[`IATP_NUM_FLAGS-1:0] : flagEn_reg;
      irq_reg    <= |(flag_reg & flagEn_reg);
    end
  end

  // Candidate selection for the next offer to the core
  assign trapRank = iatp_rank(trapClass);
  assign trapOk   = hasTrap && (trapRank > svcRank_reg);
  assign swOk     = swPend_reg && state_reg == ST_IDLE;
  assign intOk    = arbFound && state_reg == ST_IDLE;
  assign ackTrap  = state_reg == ST_OFFER && cpuAck && kind_reg == KIND_TRAP;
  assign ackInt   = state_reg == ST_OFFER && cpuAck && kind_reg == KIND_INT;
  assign ackSw    = state_reg == ST_OFFER && cpuAck && kind_reg == KIND_SW;

  // Service sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (trapOk || swOk || intOk) state_next = ST_OFFER;
      end
      ST_OFFER: begin
        if (ackTrap) state_next = ST_TRAP_SVC;
        else if (cpuAck) state_next = svcRank_reg != 2'h0 ? ST_TRAP_SVC : ST_IDLE;
      end
      ST_TRAP_SVC: begin
        if (trapOk) state_next = ST_OFFER;
        else if (trapDone) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Offer latch: vector, number and kind held until the core acknowledges
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg     <= ST_IDLE;
      kind_reg      <= KIND_INT;
      isTrap_reg    <= 1'b0;
      grantIdx_reg  <= '0;
      offerRank_reg <= 2'h0;
      offer_reg     <= 1'b0;
      vec_reg       <= 24'h000000;
      num_reg       <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      offer_reg <= state_next == ST_OFFER;
      if (state_reg != ST_OFFER && state_next == ST_OFFER) begin
        isTrap_reg <= trapOk;
        if (trapOk) begin
          kind_reg      <= KIND_TRAP;
          vec_reg       <= trapVec;
          num_reg       <= trapNum;
          offerRank_reg <= trapRank;
        end else if (swOk) begin
          kind_reg <= KIND_SW;
          vec_reg  <= {15'h0000, swNum_reg, 2'h0};
          num_reg  <= {1'b0, swNum_reg};
        end else begin
          kind_reg     <= KIND_INT;
          grantIdx_reg <= arbIdx;
          num_reg      <= `IATP_SRC_TRAP_BASE + 8'(arbIdx);
          vec_reg      <= {14'h0000, `IATP_SRC_TRAP_BASE + 8'(arbIdx), 2'h0};
        end
      end
    end
  end

  // Level forcing: set on trap acceptance, dropped when the service ends
  assign forceNext = ackTrap ? 1'b1
                   : (state_reg == ST_TRAP_SVC && trapDone && !trapOk) ? 1'b0 : forceMax_reg;

  // Trap service rank, level forcing and software trap capture
  always_ff @(posedge clk) begin
    if (srst) begin
      svcRank_reg  <= 2'h0;
      forceMax_reg <= 1'b0;
      pswLevel_reg <= cpuLevel;
      swPend_reg   <= 1'b0;
      swNum_reg    <= 7'h00;
    end else if (ce) begin
      forceMax_reg <= forceNext;
      pswLevel_reg <= forceNext ? `IATP_MAX_LEVEL : cpuLevel;
      if (ackTrap) begin
        svcRank_reg  <= offerRank_reg;
      end else if (state_reg == ST_TRAP_SVC && trapDone && !trapOk) begin
        svcRank_reg  <= 2'h0;
      end
      if (swTrapReq && !swPend_reg) begin
        swPend_reg <= 1'b1;
        swNum_reg  <= swTrapNum;
      end else if (ackSw) begin
        swPend_reg <= 1'b0;
      end
    end
  end

  assign avsReaddata    = rdata_reg;
  assign avsWaitrequest = wait_reg;
  assign offerValid     = offer_reg;
  assign offerVector    = vec_reg;
  assign offerTrapNum   = num_reg;
  assign offerIsTrap    = isTrap_reg;
  assign pswForceMax    = forceMax_reg;
  assign pswLevel       = pswLevel_reg;
  assign irq            = irq_reg;
endmodule

// file: iatp_properties.sv
// Checker of bus, offer and trap relations at the top ports
`timescale 1ns/1ps
module iatp_properties
  import iatp_pkg::*;
(
  input logic        clk,
  input logic        srst,
  input logic        ce,
  input logic [11:0] avsAddress,
  input logic        avsRead,
  input logic        avsWrite,
  input logic [31:0] avsReaddata,
  input logic        avsWaitrequest,
  input logic [3:0]  cpuLevel,
  input logic        cpuAck,
  input logic        offerValid,
  input logic [23:0] offerVector,
  input logic [7:0]  offerTrapNum,
  input logic        offerIsTrap,
  input logic        pswForceMax,
  input logic [3:0]  pswLevel
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Steps of a bus access and of an offer
  sequence busReq; (avsRead || avsWrite) && avsWaitrequest && ce; endsequence
  sequence offerHeld; offerValid && !cpuAck; endsequence
  sequence offerTaken; offerValid && cpuAck; endsequence
  bus_answer_a: assert property (busReq |=> !avsWaitrequest) else $error("bus answer late");
  wait_pulse_a: assert property (!avsWaitrequest && ce |=> avsWaitrequest) else $error("wait low too long");
  upper_zero_a: assert property (!avsWaitrequest && avsRead && avsAddress >= 12'h100 |->
    avsReaddata[31:8] == 24'h000000) else $error("upper byte not zero");
  psw_level_a: assert property ($past(ce) |-> pswLevel == (pswForceMax ? 4'hf : $past(cpuLevel)))
    else $error("level wrong");
  trap_force_a: assert property (offerTaken and offerIsTrap |=> pswForceMax) else $error("no force");
  sw_level_a: assert property (offerTaken and !offerIsTrap && !pswForceMax |=> !pswForceMax)
    else $error("forced on plain offer");
  ack_drop_a: assert property (offerTaken |=> !offerValid) else $error("offer kept after ack");
  offer_stable_a: assert property (offerHeld |=> offerValid && $stable(offerVector)
    && $stable(offerTrapNum)) else $error("offer changed");
  vector_pair_a: assert property (offerValid |-> offerVector == {14'h0000, offerTrapNum, 2'b00})
    else $error("vector and number differ");
  trap_number_a: assert property (offerValid && offerIsTrap |->
    offerTrapNum inside {8'h00, 8'h02, 8'h04, 8'h06, 8'h0a}) else $error("bad trap number");
  svc_block_a: assert property (pswForceMax |-> !offerValid || offerIsTrap) else $error("offer in service");
  reset_trap_a: assert property ($fell(srst) |-> ##[1:3] (offerValid && offerIsTrap
    && offerTrapNum == 8'h00)) else $error("no reset trap");
endmodule

bind iatp_top iatp_properties chk (.clk(clk), .srst(srst), .ce(ce), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .cpuLevel(cpuLevel),
  .cpuAck(cpuAck), .offerValid(offerValid), .offerVector(offerVector), .offerTrapNum(offerTrapNum),
  .offerIsTrap(offerIsTrap), .pswForceMax(pswForceMax), .pswLevel(pswLevel));

// file: iatp_core_model.sv
// Behavioural core that accepts offers and ends trap services
`timescale 1ns/1ps
module iatp_core_model (
  input  logic        clk,
  input  logic        srst,
  input  logic        hold,
  input  logic        offerValid,
  input  logic [23:0] offerVector,
  input  logic [7:0]  offerTrapNum,
  input  logic        offerIsTrap,
  output logic        cpuAck,
  output logic        trapDone,
  output logic [23:0] lastVec,
  output logic [7:0]  lastNum,
  output logic        lastTrap,
  output logic [7:0]  ackCount
);
  logic [3:0] waitCnt;
  logic [3:0] svcCnt;
  logic       svc;
  // Ack after two waiting cycles, end a trap service twelve later
  always_ff @(posedge clk) begin
    if (srst) begin
      {cpuAck, trapDone, svc, waitCnt, svcCnt, ackCount} <= '0;
    end else begin
      cpuAck <= 1'b0;
      trapDone <= 1'b0;
      waitCnt <= (offerValid && !cpuAck && !hold) ? waitCnt + 4'h1 : 4'h0;
      if (offerValid && !cpuAck && !hold && waitCnt == 4'h2) begin
        cpuAck <= 1'b1;
        {lastVec, lastNum, lastTrap} <= {offerVector, offerTrapNum, offerIsTrap};
        ackCount <= ackCount + 8'h01;
        svc <= svc | offerIsTrap;
        svcCnt <= 4'h0;
      end else if (svc) begin
        svcCnt <= svcCnt + 4'h1;
        if (svcCnt == 4'hb) begin
          trapDone <= 1'b1;
          svc <= 1'b0;
        end
      end
    end
  end
endmodule

// file: interrupt_and_trap_priority_tb.sv
// Register, arbitration and trap tests of the interrupt block
`timescale 1ns/1ps
module interrupt_and_trap_priority_tb;
  import iatp_pkg::*;
  logic        clk, srst, ce, avsRead, avsWrite, avsWaitrequest, swTrapReq, cpuAck, trapDone, hold;
  logic        offerValid, offerIsTrap, pswForceMax, irq, lastTrap;
  logic [11:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, rd;
  logic [3:0]  avsByteenable, cpuLevel, pswLevel;
  logic [7:0]  srcReq, offerTrapNum, lastNum, ackCount, acks;
  logic [23:0] offerVector, lastVec;
  logic [9:0]  trapLines;
  logic [6:0]  swTrapNum;
  logic [7:0]  trapNums [10] = '{8'h02, 8'h04, 8'h06, 8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h00, 8'h00};
  int          fail_count, comparisons;

  iatp_top #(.NUM_SRC(8)) dut (.clk(clk), .srst(srst), .ce(ce), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .srcReq(srcReq), .swResetEvt(trapLines[8]), .wdtOverflowEvt(trapLines[9]),
    .nmiEvt(trapLines[0]), .stackOverflowEvt(trapLines[1]), .stackUnderflowEvt(trapLines[2]),
    .classBEvt(trapLines[7:3]), .swTrapReq(swTrapReq), .swTrapNum(swTrapNum), .cpuLevel(cpuLevel),
    .cpuAck(cpuAck), .trapDone(trapDone), .offerValid(offerValid), .offerVector(offerVector),
    .offerTrapNum(offerTrapNum), .offerIsTrap(offerIsTrap), .pswForceMax(pswForceMax), .pswLevel(pswLevel),
    .irq(irq));

  iatp_core_model core (.clk(clk), .srst(srst), .hold(hold), .offerValid(offerValid), .offerVector(offerVector),
    .offerTrapNum(offerTrapNum), .offerIsTrap(offerIsTrap), .cpuAck(cpuAck), .trapDone(trapDone),
    .lastVec(lastVec), .lastNum(lastNum), .lastTrap(lastTrap), .ackCount(ackCount));

  // Clock and run limit
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    check("runTime", 32'h0, 32'h1);
    finish_test;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    {avsAddress, avsWritedata, avsByteenable, avsRead, avsWrite} <= {a, d, be, !wr, wr};
    @(posedge clk);
    while (avsWaitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        check("waitrequest", 32'h0, 32'h1);
        finish_test;
      end
      @(posedge clk);
    end
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    avs(1'b0, a, 32'h0, 4'hf);
    check(what, rd, exp);
  endtask

  task automatic wait_ack;
    int n;
    n = 0;
    while (ackCount === acks && n < 300) begin
      n++;
      @(posedge clk);
    end
    if (ackCount === acks) begin
      check("ackWait", 32'h0, 32'h1);
      finish_test;
    end
  endtask

  task automatic offer_chk(input logic [7:0] num, input logic trap);
    check("trapNum", lastNum, num);
    check("vector", lastVec, {num, 2'b00});
    check("isTrap", lastTrap, trap);
  endtask

  task automatic pulse(input logic [7:0] src, input logic [9:0] trp);
    @(posedge clk);
    srcReq <= src;
    trapLines <= trp;
    @(posedge clk);
    srcReq <= 8'h00;
    trapLines <= 10'h000;
  endtask

  // Main sequence
  initial begin
    {srst, ce, avsRead, avsWrite, swTrapReq, hold} = 6'b110000;
    {avsAddress, avsWritedata, avsByteenable, srcReq, trapLines, swTrapNum} = '0;
    {cpuLevel, fail_count, comparisons, acks} = '0;
    cpuLevel = 4'h3;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    wait_ack;
    offer_chk(8'h00, 1'b1);
    rdchk("src0", 12'h100, 32'h0);
    rdchk("unmapped", 12'h080, 32'h0);
    avs(1'b1, 12'h104, 32'h1234567f, 4'hf);
    rdchk("src1", 12'h104, 32'h7f);
    avs(1'b1, 12'h104, 32'h0, 4'he);
    rdchk("src1Lane", 12'h104, 32'h7f);
    acks = ackCount;
    avs(1'b1, 12'h108, 32'h08, 4'hf);
    pulse(8'h04, 10'h000);
    repeat (6) @(posedge clk);
    check("disabled", ackCount, acks);
    rdchk("src2Flag", 12'h108, 32'h88);
    $display("test registers done");
    hold <= 1'b1;
    avs(1'b1, 12'h110, 32'h55, 4'hf);
    avs(1'b1, 12'h114, 32'h56, 4'hf);
    avs(1'b1, 12'h118, 32'h4b, 4'hf);
    pulse(8'h70, 10'h000);
    repeat (4) @(posedge clk);
    acks = ackCount;
    hold <= 1'b0;
    wait_ack;
    offer_chk(8'h15, 1'b0);
    acks = ackCount;
    wait_ack;
    offer_chk(8'h14, 1'b0);
    rdchk("src5Clear", 12'h114, 32'h56);
    rdchk("src6Low", 12'h118, 32'hcb);
    acks = ackCount;
    cpuLevel <= 4'h1;
    wait_ack;
    offer_chk(8'h16, 1'b0);
    $display("test arbitration done");
    for (int i = 0; i < 10; i++) begin
      acks = ackCount;
      pulse(8'h00, 10'h001 << i);
      wait_ack;
      offer_chk(trapNums[i], 1'b1);
      repeat (20) @(posedge clk);
    end
    rdchk("flags", 12'h000, 32'h1ff);
    avs(1'b1, 12'h004, 32'h1ff, 4'hf);
    rdchk("flagsClr", 12'h000, 32'h0);
    avs(1'b1, 12'h114, 32'h56, 4'hf);
    acks = ackCount;
    pulse(8'h00, 10'h001);
    wait_ack;
    pulse(8'h20, 10'h000);
    repeat (4) @(posedge clk);
    check("svcBlock", ackCount, acks + 8'h01);
    check("pswLevel", pswLevel, 4'hf);
    acks = ackCount;
    wait_ack;
    offer_chk(8'h15, 1'b0);
    $display("test traps done");
    for (int j = 0; j < 2; j++) begin
      acks = ackCount;
      @(posedge clk);
      swTrapNum <= j ? 7'h01 : 7'h7f;
      swTrapReq <= 1'b1;
      @(posedge clk);
      swTrapReq <= 1'b0;
      wait_ack;
      offer_chk(j ? 8'h01 : 8'h7f, 1'b0);
      repeat (4) @(posedge clk);
    end
    avs(1'b1, 12'h004, 32'h1ff, 4'hf);
    avs(1'b1, 12'h008, 32'h1, 4'hf);
    rdchk("enable", 12'h008, 32'h1);
    pulse(8'h00, 10'h002);
    repeat (30) @(posedge clk);
    check("irqMasked", irq, 1'b0);
    pulse(8'h00, 10'h001);
    repeat (30) @(posedge clk);
    check("irqSet", irq, 1'b1);
    rdchk("flagsIrq", 12'h000, 32'h3);
    avs(1'b1, 12'h004, 32'h3, 4'hf);
    repeat (3) @(posedge clk);
    check("irqClr", irq, 1'b0);
    ce <= 1'b0;
    pulse(8'h00, 10'h001);
    repeat (3) @(posedge clk);
    check("ceFreeze", irq, 1'b0);
    ce <= 1'b1;
    $display("test interrupt done");
    finish_test;
  end
endmodule
